/* hdl/fma_unit.sv */
`timescale 1ns/10ps
module fma_unit (
    input wire logic clk,
    input wire logic reset,
    input wire logic issue_valid,
    input wire logic [31:0] issue_instr,
    input wire logic [31:0] rs_value,
    input wire logic [31:0] rt_value,
    input wire logic dsp_present,
    input wire logic dsp_enabled,
    input wire logic acc_read_req,
    input wire logic [1:0] acc_read_sel,
    output logic busy,
    output logic acc_read_stall,
    output logic [31:0] acc_high_half,
    output logic [31:0] acc_low_half,
    output logic gpr_write_en,
    output logic [31:0] gpr_write_data,
    output logic ouflag_write_en,
    output logic [3:0] ouflag_acc_set,
    output logic ouflag_word_set,
    output logic reserved_instr_exc,
    output logic dsp_disabled_exc
);
    fma_pkg::fma_op_e dec_op;
    logic [1:0] dec_acc;
    logic take;

    // the two-bit countdown serves latencies of one to four cycles
    if (fma_pkg::MUL_LATENCY < 1 || fma_pkg::MUL_LATENCY > 4) begin : g_bad_latency
        $error("multiply latency out of range");
    end

    fma_decode u_decode (
        .instr(issue_instr),
        .op(dec_op),
        .acc_sel(dec_acc)
    );

    // pipeline state
    logic [63:0] acc_q [4];
    logic [63:0] acc_d [4];
    fma_pkg::fma_op_e op_q, op_d;
    logic [1:0] sel_q, sel_d;
    logic [31:0] a_q, a_d, b_q, b_d;
    logic [1:0] cnt_q, cnt_d;
    logic busy_q, busy_d;
    logic stall_q, stall_d;
    logic [31:0] hi_q, hi_d, lo_q, lo_d;
    logic gwe_q, gwe_d;
    logic [31:0] gwd_q, gwd_d;
    logic owe_q, owe_d;
    logic [3:0] oacc_q, oacc_d;
    logic oword_q, oword_d;
    logic rie_q, rie_d, dde_q, dde_d;

    // products
    logic signed [63:0] prod_word;
    logic signed [31:0] prod_hi, prod_lo;
    logic [31:0] q31_hi, q31_lo, frac_word;
    logic sat_hi, sat_lo, sat_word;
    logic [63:0] diff_ext, frac_ext;

    // arithmetic on captured operands
    always_comb begin
        prod_word = $signed(a_q) * $signed(b_q);
        prod_hi = $signed(a_q[31:16]) * $signed(b_q[31:16]);
        prod_lo = $signed(a_q[15:0]) * $signed(b_q[15:0]);
        sat_word = (a_q == fma_pkg::Q31_MIN) && (b_q == fma_pkg::Q31_MIN);
        frac_word = sat_word ? fma_pkg::Q31_MAX : prod_word[62:31];
        sat_hi = (a_q[31:16] == fma_pkg::Q15_MIN) && (b_q[31:16] == fma_pkg::Q15_MIN);
        sat_lo = (a_q[15:0] == fma_pkg::Q15_MIN) && (b_q[15:0] == fma_pkg::Q15_MIN);
        q31_hi = sat_hi ? fma_pkg::Q31_MAX : {prod_hi[30:0], 1'b0};
        q31_lo = sat_lo ? fma_pkg::Q31_MAX : {prod_lo[30:0], 1'b0};
        diff_ext = {{32{prod_hi[31]}}, prod_hi} - {{32{prod_lo[31]}}, prod_lo};
        frac_ext = {{32{q31_hi[31]}}, q31_hi} - {{32{q31_lo[31]}}, q31_lo};
    end

    // issue is accepted only when idle and the extension is usable
    assign take = issue_valid && !busy_q && dec_op != fma_pkg::FMA_OP_NONE
        && dsp_present && dsp_enabled;

    // next-state for operation, accumulators and outputs
    always_comb begin
        op_d = op_q;
        sel_d = sel_q;
        a_d = a_q;
        b_d = b_q;
        cnt_d = cnt_q;
        busy_d = busy_q;
        for (int i = 0; i < 4; i++) begin
            acc_d[i] = acc_q[i];
        end
        gwe_d = 1'b0;
        gwd_d = gwd_q;
        owe_d = 1'b0;
        oacc_d = 4'h0;
        oword_d = 1'b0;
        // traps come only from presence/enable, never from operand values
        rie_d = issue_valid && !busy_q && dec_op != fma_pkg::FMA_OP_NONE
            && !dsp_present;
        dde_d = issue_valid && !busy_q && dec_op != fma_pkg::FMA_OP_NONE
            && dsp_present && !dsp_enabled;
        if (take) begin
            op_d = dec_op;
            sel_d = dec_acc;
            a_d = rs_value;
            b_d = rt_value;
            cnt_d = 2'(fma_pkg::MUL_LATENCY - 1);
            busy_d = 1'b1;
        end else if (busy_q && cnt_q != 2'h0) begin
            cnt_d = cnt_q - 2'h1;
        end else if (busy_q) begin
            busy_d = 1'b0;
            case (op_q)
                fma_pkg::FMA_OP_FRAC_WORD: begin
                    gwe_d = 1'b1;
                    gwd_d = frac_word;
                    // accumulators are left untouched, ac0 included
                    owe_d = sat_word;
                    oword_d = sat_word;
                end
                fma_pkg::FMA_OP_INT_MSA: begin
                    acc_d[sel_q] = acc_q[sel_q] + diff_ext;
                    // no flag write at all
                end
                fma_pkg::FMA_OP_FRAC_MSA: begin
                    acc_d[sel_q] = acc_q[sel_q] + frac_ext;
                    owe_d = sat_hi || sat_lo;
                    oacc_d = (sat_hi || sat_lo) ? (4'h1 << sel_q) : 4'h0;
                end
                fma_pkg::FMA_OP_SIGNED_SIGNED_WORD_MULTIPLY: begin
                    acc_d[sel_q] = prod_word;
                end
                default: begin
                end
            endcase
        end
    end

    // accumulator read port with interlock
    always_comb begin
        stall_d = 1'b0;
        hi_d = hi_q;
        lo_d = lo_q;
        if (acc_read_req) begin
            if (busy_d || take) begin
                stall_d = 1'b1;
            end else begin
                hi_d = acc_d[acc_read_sel][63:32];
                lo_d = acc_d[acc_read_sel][31:0];
            end
        end
    end

    // read port registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stall_q <= 1'b0;
            hi_q <= 32'h0;
            lo_q <= 32'h0;
        end else begin
            stall_q <= stall_d;
            hi_q <= hi_d;
            lo_q <= lo_d;
        end
    end

    // operation, accumulator and result registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 4; i++) begin
                acc_q[i] <= fma_pkg::ACC_RESET;
            end
            op_q <= fma_pkg::FMA_OP_NONE;
            sel_q <= 2'h0;
            a_q <= 32'h0;
            b_q <= 32'h0;
            cnt_q <= 2'h0;
            busy_q <= 1'b0;
            gwe_q <= 1'b0;
            gwd_q <= 32'h0;
            owe_q <= 1'b0;
            oacc_q <= 4'h0;
            oword_q <= 1'b0;
            rie_q <= 1'b0;
            dde_q <= 1'b0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                acc_q[i] <= acc_d[i];
            end
            op_q <= op_d;
            sel_q <= sel_d;
            a_q <= a_d;
            b_q <= b_d;
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            gwe_q <= gwe_d;
            gwd_q <= gwd_d;
            owe_q <= owe_d;
            oacc_q <= oacc_d;
            oword_q <= oword_d;
            rie_q <= rie_d;
            dde_q <= dde_d;
        end
    end

    assign busy = busy_q;
    assign acc_read_stall = stall_q;
    assign acc_high_half = hi_q;
    assign acc_low_half = lo_q;
    assign gpr_write_en = gwe_q;
    assign gpr_write_data = gwd_q;
    assign ouflag_write_en = owe_q;
    assign ouflag_acc_set = oacc_q;
    assign ouflag_word_set = oword_q;
    assign reserved_instr_exc = rie_q;
    assign dsp_disabled_exc = dde_q;

    // checks on the completion path, the traps, the latency and the read stall
    chk_word_sat_value: assert property (@(posedge clk) disable iff (reset)
        busy_q && cnt_q == 2'h0 && op_q == fma_pkg::FMA_OP_FRAC_WORD
        && a_q == fma_pkg::Q31_MIN && b_q == fma_pkg::Q31_MIN
        |=> gpr_write_en && gpr_write_data == fma_pkg::Q31_MAX)
        else $error("saturated word result wrong");
    chk_word_flag_pair: assert property (@(posedge clk) disable iff (reset)
        oword_q |-> gwe_q && gwd_q == fma_pkg::Q31_MAX)
        else $error("word flag without saturated result");
    chk_flag_onehot: assert property (@(posedge clk) disable iff (reset)
        $onehot0(oacc_q)) else $error("more than one accumulator flag");
    chk_frac_msa_flag: assert property (@(posedge clk) disable iff (reset)
        busy_q && cnt_q == 2'h0 && op_q == fma_pkg::FMA_OP_FRAC_MSA
        && ((a_q[31:16] == fma_pkg::Q15_MIN && b_q[31:16] == fma_pkg::Q15_MIN)
        || (a_q[15:0] == fma_pkg::Q15_MIN && b_q[15:0] == fma_pkg::Q15_MIN))
        |=> ouflag_write_en && ouflag_acc_set[$past(sel_q)])
        else $error("frac msa saturation flag missing");
    chk_int_msa_noflag: assert property (@(posedge clk) disable iff (reset)
        busy_q && cnt_q == 2'h0 && op_q == fma_pkg::FMA_OP_INT_MSA |=> !owe_q)
        else $error("int msa wrote flags");
    chk_word_keeps_acc: assert property (@(posedge clk) disable iff (reset)
        busy_q && cnt_q == 2'h0 && op_q == fma_pkg::FMA_OP_FRAC_WORD
        |=> acc_q[1] == $past(acc_q[1]) && acc_q[2] == $past(acc_q[2])
        && acc_q[3] == $past(acc_q[3]))
        else $error("frac word changed accumulator");
    chk_trap_exclusive: assert property (@(posedge clk) disable iff (reset)
        !(rie_q && dde_q)) else $error("both traps raised");
    chk_trap_no_issue: assert property (@(posedge clk) disable iff (reset)
        (rie_q || dde_q) |-> !gwe_q) else $error("trap with write");
    chk_signed_word_multiply_result: assert property (@(posedge clk) disable iff (reset)
        take && dec_op == fma_pkg::FMA_OP_SIGNED_SIGNED_WORD_MULTIPLY
        |-> ##3 $signed(acc_q[$past(dec_acc, 3)])
        == $signed($past(rs_value, 3)) * $signed($past(rt_value, 3)))
        else $error("signed multiply result wrong");
    chk_busy_len: assert property (@(posedge clk) disable iff (reset)
        take |=> busy_q [*2] ##1 !busy_q) else $error("latency wrong");
    chk_read_stall: assert property (@(posedge clk) disable iff (reset)
        acc_read_req && busy_q && cnt_q != 2'h0 |=> acc_read_stall)
        else $error("read not stalled");

    // only the selected accumulator may move
    for (genvar g = 0; g < 4; g++) begin : g_acc_keep
        chk_acc_unselected: assert property (@(posedge clk) disable iff (reset)
            sel_q != 2'(g) |=> acc_q[g] == $past(acc_q[g]))
            else $error("unselected accumulator changed");
    end

    // main scenarios reached
    cov_int_msa: cover property (@(posedge clk) busy_q && op_q == fma_pkg::FMA_OP_INT_MSA);
    cov_word_sat: cover property (@(posedge clk) oword_q);
    cov_frac_msa_sat: cover property (@(posedge clk) oacc_q != 4'h0);
    cov_stall: cover property (@(posedge clk) acc_read_stall);
    cov_trap: cover property (@(posedge clk) dsp_disabled_exc);
endmodule : fma_unit

/* common/fma_pkg.sv */
// Functional notes
// - frac word multiply: signed 64-bit product, shift left one, keep upper word.
// - both word operands 0x80000000 give 0x7fffffff instead.
// - frac word multiply saturation sets overflow flag bit 21, else unchanged.
// - frac word multiply may disturb accumulator zero; accumulators one to three kept.
// - reserved-instruction trap if extension absent; dsp-disabled trap if turned off.
// - no operand-dependent exceptions; overflow only via flags or saturation.
// - int halfword msa: upper product minus lower, sign-extended, added to accumulator.
// - int halfword msa never touches overflow flag bits.
// - two-bit accumulator field selects accumulator 0 to 3; 0 is base pair.
// - q15 products shifted to q31; both inputs 0x8000 give 0x7fffffff.
// - frac msa subtracts lower q31 product, sign-extends to 64, adds to accumulator.
// - frac msa saturation sets flag bit 16 plus accumulator number.
// - signed word multiply writes full signed 64-bit product to accumulator.
// - signed word multiply never raises an arithmetic exception.
// - signed word multiply decode: major 000000, minor 00110010, extension 111100.
// - int halfword msa decode: major 000000, minor 10110010, extension 111100.
// - accumulator reads stall until pending multiply result is written.
package fma_pkg;
    localparam logic [5:0] MAJOR_OPCODE_GROUP = 6'h00;
    localparam logic [5:0] EXTENSION_SUBGROUP_CODE = 6'h3c;
    localparam logic [7:0] MINOR_SIGNED_WORD_MULTIPLY = 8'h32;
    localparam logic [7:0] MINOR_INT_HALF_MUL_SUB_ACC = 8'hb2;
    localparam logic [7:0] MINOR_FRAC_HALF_MUL_SUB_ACC_SAT = 8'hf2;
    localparam logic [7:0] MINOR_FRAC_WORD_MULTIPLY_SAT = 8'h72;
    localparam int MAJOR_LSB = 26;
    localparam int MINOR_LSB = 6;
    localparam int ACC_SEL_LSB = 14;
    localparam int RT_LSB = 21;
    localparam int RS_LSB = 16;
    localparam int OUFLAG_WORD_BIT = 21;
    localparam int OUFLAG_ACC_BASE_BIT = 16;
    localparam logic [31:0] Q31_MIN = 32'h8000_0000;
    localparam logic [31:0] Q31_MAX = 32'h7fff_ffff;
    localparam logic [15:0] Q15_MIN = 16'h8000;
    localparam logic [63:0] ACC_RESET = 64'h0;
    localparam int MUL_LATENCY = 2;
    typedef enum logic [2:0] {
        FMA_OP_NONE,
        FMA_OP_FRAC_WORD,
        FMA_OP_INT_MSA,
        FMA_OP_FRAC_MSA,
        FMA_OP_SIGNED_SIGNED_WORD_MULTIPLY
    } fma_op_e;
endpackage : fma_pkg

/* hdl/fma_decode.sv */
`timescale 1ns/10ps
// instruction word to operation class
module fma_decode (
    input wire logic [31:0] instr,
    output fma_pkg::fma_op_e op,
    output logic [1:0] acc_sel
);
    logic [5:0] major;
    logic [7:0] minor;
    logic [5:0] ext;

    // field extraction and minor-code match
    always_comb begin
        major = instr[fma_pkg::MAJOR_LSB +: 6];
        minor = instr[fma_pkg::MINOR_LSB +: 8];
        ext = instr[5:0];
        acc_sel = instr[fma_pkg::ACC_SEL_LSB +: 2];
        op = fma_pkg::FMA_OP_NONE;
        if (major == fma_pkg::MAJOR_OPCODE_GROUP && ext == fma_pkg::EXTENSION_SUBGROUP_CODE) begin
            if (minor == fma_pkg::MINOR_SIGNED_WORD_MULTIPLY) begin
                op = fma_pkg::FMA_OP_SIGNED_SIGNED_WORD_MULTIPLY;
            end else if (minor == fma_pkg::MINOR_INT_HALF_MUL_SUB_ACC) begin
                op = fma_pkg::FMA_OP_INT_MSA;
            end else if (minor == fma_pkg::MINOR_FRAC_HALF_MUL_SUB_ACC_SAT) begin
                op = fma_pkg::FMA_OP_FRAC_MSA;
            end else if (minor == fma_pkg::MINOR_FRAC_WORD_MULTIPLY_SAT) begin
                op = fma_pkg::FMA_OP_FRAC_WORD;
            end
        end
    end
endmodule : fma_decode

/* bench/fma_pipe_model.sv */
`timescale 1ns/10ps
// pipeline side: merges set-only flag pulses and catches register writes
module fma_pipe_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic gpr_write_en,
    input wire logic [31:0] gpr_write_data,
    input wire logic ouflag_write_en,
    input wire logic [3:0] ouflag_acc_set,
    input wire logic ouflag_word_set,
    output logic [31:0] gpr_q,
    output logic [31:0] ctl_q
);
    // flags only ever get set, never cleared by the unit
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gpr_q <= 32'h0;
            ctl_q <= 32'h0;
        end else begin
            if (gpr_write_en) begin
                gpr_q <= gpr_write_data;
            end
            if (ouflag_write_en) begin
                ctl_q[fma_pkg::OUFLAG_WORD_BIT] <= ctl_q[fma_pkg::OUFLAG_WORD_BIT]
                    | ouflag_word_set;
                ctl_q[fma_pkg::OUFLAG_ACC_BASE_BIT +: 4] <=
                    ctl_q[fma_pkg::OUFLAG_ACC_BASE_BIT +: 4] | ouflag_acc_set;
            end
        end
    end
endmodule : fma_pipe_model

/* bench/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    logic clk, reset, issue_valid, dsp_present, dsp_enabled, acc_read_req;
    logic [31:0] issue_instr, rs_value, rt_value, acc_high_half, acc_low_half;
    logic [31:0] gpr_write_data, gpr_seen, ctl_seen;
    logic [1:0] acc_read_sel;
    logic [3:0] ouflag_acc_set;
    logic busy, acc_read_stall, gpr_write_en, ouflag_write_en, ouflag_word_set;
    logic reserved_instr_exc, dsp_disabled_exc;
    int mismatches, n_compared, stalls;

    fma_unit DUT (.clk, .reset, .issue_valid, .issue_instr, .rs_value, .rt_value,
        .dsp_present, .dsp_enabled, .acc_read_req, .acc_read_sel, .busy, .acc_read_stall,
        .acc_high_half, .acc_low_half, .gpr_write_en, .gpr_write_data, .ouflag_write_en,
        .ouflag_acc_set, .ouflag_word_set, .reserved_instr_exc, .dsp_disabled_exc);

    fma_pipe_model PIPE (.clk, .reset, .gpr_write_en, .gpr_write_data, .ouflag_write_en,
        .ouflag_acc_set, .ouflag_word_set, .gpr_q(gpr_seen), .ctl_q(ctl_seen));

    // verdict and run end
    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    task cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_word

    task cmp_acc(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_acc

    // instruction word with register fields zero
    function automatic logic [31:0] enc(input logic [7:0] minor, input logic [1:0] acc);
        return {fma_pkg::MAJOR_OPCODE_GROUP, 10'h0, acc, minor,
            fma_pkg::EXTENSION_SUBGROUP_CODE};
    endfunction : enc

    // one take, then results two edges later, one more for the model
    task issue(input logic [7:0] minor, input logic [1:0] acc, input logic [31:0] a,
        input logic [31:0] b);
        issue_instr = enc(minor, acc);
        rs_value = a;
        rt_value = b;
        issue_valid = 1'b1;
        @(posedge clk);
        #1 issue_valid = 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask : issue

    // read retried while stalled, bounded
    task rd_acc(input logic [1:0] sel, input logic [63:0] exp);
        int i;
        acc_read_req = 1'b1;
        acc_read_sel = sel;
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            #1;
            if (acc_read_stall !== 1'b1) break;
        end
        acc_read_req = 1'b0;
        stalls = i;
        if (i == 4) begin
            mismatches++;
            end_of_test();
        end
        @(posedge clk);
        #1 cmp_acc({acc_high_half, acc_low_half}, exp);
    endtask : rd_acc

    // offer with extension absent or off; expect {reserved, disabled}
    task trap(input logic p, input logic e, input logic [1:0] exp);
        logic [1:0] seen;
        dsp_present = p;
        dsp_enabled = e;
        issue_instr = enc(fma_pkg::MINOR_FRAC_WORD_MULTIPLY_SAT, 2'd0);
        issue_valid = 1'b1;
        seen = 2'b00;
        @(posedge clk);
        #1 issue_valid = 1'b0;
        seen = seen | {reserved_instr_exc, dsp_disabled_exc};
        @(posedge clk);
        #1 seen = seen | {reserved_instr_exc, dsp_disabled_exc};
        dsp_present = 1'b1;
        dsp_enabled = 1'b1;
        cmp_word({30'h0, seen}, {30'h0, exp});
        @(posedge clk);
        #1;
    endtask : trap

    // clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // main sequence
    initial begin
        reset = 1'b1;
        issue_valid = 1'b0;
        issue_instr = 32'h0;
        rs_value = 32'h0;
        rt_value = 32'h0;
        dsp_present = 1'b1;
        dsp_enabled = 1'b1;
        acc_read_req = 1'b0;
        acc_read_sel = 2'd0;
        mismatches = 0;
        n_compared = 0;
        repeat (12) @(posedge clk);
        #1 reset = 1'b0;
        rd_acc(2'd2, 64'h0);
        issue(fma_pkg::MINOR_FRAC_WORD_MULTIPLY_SAT, 2'd0, 32'h4000_0000, 32'h4000_0000);
        cmp_word(gpr_seen, 32'h2000_0000);
        cmp_word(ctl_seen, 32'h0);
        issue(fma_pkg::MINOR_SIGNED_WORD_MULTIPLY, 2'd1, 32'hffff_fffe, 32'h3);
        rd_acc(2'd1, 64'hffff_ffff_ffff_fffa);
        issue(fma_pkg::MINOR_FRAC_WORD_MULTIPLY_SAT, 2'd0, 32'h8000_0000, 32'h8000_0000);
        cmp_word(gpr_seen, 32'h7fff_ffff);
        cmp_word(ctl_seen, 32'h0020_0000);
        rd_acc(2'd1, 64'hffff_ffff_ffff_fffa);
        issue(fma_pkg::MINOR_INT_HALF_MUL_SUB_ACC, 2'd1, 32'h0002_0003, 32'h0004_fffb);
        rd_acc(2'd1, 64'h11);
        issue(fma_pkg::MINOR_INT_HALF_MUL_SUB_ACC, 2'd1, 32'h0000_0001, 32'h0000_0005);
        rd_acc(2'd1, 64'hc);
        cmp_word(ctl_seen, 32'h0020_0000);
        issue(fma_pkg::MINOR_FRAC_HALF_MUL_SUB_ACC_SAT, 2'd3, 32'h8000_0001, 32'h8000_0002);
        rd_acc(2'd3, 64'h7fff_fffb);
        cmp_word(ctl_seen, 32'h0028_0000);
        issue_instr = enc(fma_pkg::MINOR_SIGNED_WORD_MULTIPLY, 2'd2);
        rs_value = 32'h0001_0000;
        rt_value = 32'h0001_0000;
        issue_valid = 1'b1;
        @(posedge clk);
        #1 issue_valid = 1'b0;
        cmp_word({31'h0, busy}, 32'h1);
        rd_acc(2'd2, 64'h1_0000_0000);
        cmp_word(stalls, 32'(fma_pkg::MUL_LATENCY - 1));
        trap(1'b0, 1'b1, 2'b10);
        trap(1'b1, 1'b0, 2'b01);
        cmp_word(gpr_seen, 32'h7fff_ffff);
        end_of_test();
    end
endmodule : tb_top
